// file: common/sleep_clock_defs.vh
`ifndef SLEEP_CLOCK_DEFS_VH
`define SLEEP_CLOCK_DEFS_VH

// register addresses (8-bit special function space)
`define ADDR_SLEEP_CTRL 8'hbe
`define ADDR_CLOCK_SELECT 8'hc6
`define ADDR_POWER_CONTROL 8'h87

// sleep_and_oscillator_control fields
`define SLP_CAL_DIS 7
`define SLP_CRYSTAL_STABLE_FLAG 6
`define SLP_FAST_RC_STABLE_FLAG 5
`define SLP_RST_HI 4
`define SLP_RST_LO 3
`define SLP_PD 2
`define SLP_MODE_HI 1
`define SLP_MODE_LO 0

// clock_select_register fields
`define CLK_SLOW_SEL 7
`define CLK_SRC_SEL 6
`define CLK_TICK_HI 5
`define CLK_TICK_LO 3
`define CLK_SPEED 0
`define CLK_TICK_RESET 3'h1

// power_control_register fields
`define POWER_CONTROL_REGISTER_ENTER 0
`define POWER_CONTROL_REGISTER_SPARE_HI 7
`define POWER_CONTROL_REGISTER_SPARE_LO 2

// reset causes
`define RST_POWER_ON 2'h0
`define RST_PIN 2'h1
`define RST_WATCHDOG 2'h2

// power modes
`define MODE_ACTIVE 2'h0
`define MODE_LIGHT 2'h1
`define MODE_DEEP 2'h2
`define MODE_DEEPEST 2'h3

// timing
`define CLK_MHZ 200
`define CAL_MAX_US 2000
`define CAL_CYCLES (`CAL_MAX_US * `CLK_MHZ)
`define SLOW_DIV_DEFAULT 6104

`endif

// file: src/sync2.v
`timescale 1ns/1ps
module sync2 #(
  parameter WIDTH = 1
) (
  // clock and reset
  input wire clk,
  input wire reset_n,
  // data
  input wire [WIDTH-1:0] d,
  output reg [WIDTH-1:0] q
);
  reg [WIDTH-1:0] meta;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta <= {WIDTH{1'b0}};
      q <= {WIDTH{1'b0}};
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// file: src/sleep_clock_ctrl.v
`timescale 1ns/1ps
`include "sleep_clock_defs.vh"

// How it works
// RL1 - bit 7 disables slow RC calibration; 0 allows, 1 disables
// RL2 - writing 1 there takes effect only once fast RC is system clock
// RL3 - disable bit returns to 0 after deep or deepest sleep
// RL4 - bit 6 reads 1 when crystal is powered and stable
// RL5 - software waits 64 us after crystal stable before selecting it
// RL6 - bit 5 reads 1 when fast RC is powered and stable
// RL7 - bits 4:3 hold last reset cause: power-on, pin, watchdog
// RL8 - bit 2 resets to 1 and powers down the unselected fast source
// RL9 - setting bit 2 during calibration waits for calibration end
// RL10 - mode field selects active, light, deep or deepest sleep
// RL11 - software sets mode then enter bit; enter bit always reads 0
// RL12 - enabled port or timer interrupt or power-on wakes, clearing mode
// RL13 - system clock is 16 MHz RC or 32 MHz crystal per select bit
// RL14 - source change happens only once new source is stable
// RL15 - speed bit mirrors source actually in use
// RL16 - software uses stable crystal before radio operation
// RL17 - after any reset the slow RC is enabled and selected
// RL18 - slow clock ticks sleep timer, watchdog and MAC timer strobe
// RL19 - slow crystal and slow RC never run together
// RL20 - software changes slow source only while on fast RC
// RL21 - fast RC calibrated while crystal in use and RC powered
// RL22 - slow RC calibrated in active mode on stable crystal only; code starts it only there, but a running one continues into deepest sleep
// RL23 - calibration up to 2 ms finishes before light or deep sleep
// RL24 - disabling calibration lets a running calibration complete
module sleep_clock_ctrl #(
  parameter CAL_CYCLES = `CAL_CYCLES,
  parameter SLOW_DIV = `SLOW_DIV_DEFAULT
) (
  // clock and reset
  input wire clk,
  input wire reset_n,
  // register port
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  // reset cause, asynchronous pulses from reset logic
  input wire por_event,
  input wire pin_reset_event,
  input wire watchdog_reset_event,
  // wake sources
  input wire port_irq,
  input wire sleep_timer_irq,
  // oscillator status pins
  input wire crystal_ready,
  input wire fast_rc_ready,
  input wire slow_clock_in,
  // oscillator controls
  output reg fast_crystal_enable,
  output reg fast_rc_enable,
  output reg slow_crystal_enable,
  output reg slow_rc_enable,
  output reg sys_clock_is_crystal,
  output reg fast_rc_cal_active,
  output reg slow_rc_cal_active,
  // power and timers
  output reg [1:0] power_state,
  output reg cpu_halt,
  output reg slow_tick
);
  localparam [3:0] ST_ACTIVE = 4'h1;
  localparam [3:0] ST_DRAIN = 4'h2;
  localparam [3:0] ST_SLEEP = 4'h4;
  localparam [3:0] ST_IDLE = 4'h8;

  wire [2:0] rst_sync;
  wire [3:0] osc_sync;
  wire xtal_ok = osc_sync[0];
  wire rc_ok = osc_sync[1];
  wire slow_lvl = osc_sync[2];
  wire wake = osc_sync[3];

  sync2 #(.WIDTH(3)) u_rst_sync (
    .clk(clk),
    .reset_n(reset_n),
    .d({watchdog_reset_event, pin_reset_event, por_event}),
    .q(rst_sync)
  );
  sync2 #(.WIDTH(4)) u_osc_sync (
    .clk(clk),
    .reset_n(reset_n),
    .d({port_irq | sleep_timer_irq | por_event, slow_clock_in, fast_rc_ready, crystal_ready}),
    .q(osc_sync)
  );

  reg [3:0] state;
  reg [1:0] mode;
  reg cal_dis_req;
  reg cal_dis;
  reg pd_req;
  reg pd;
  reg [1:0] rst_cause;
  reg src_sel;
  reg slow_sel;
  reg [2:0] tick_speed;
  reg [5:0] power_control_register_spare;
  reg [31:0] cal_cnt;
  reg [15:0] div_cnt;
  reg slow_prev;

  wire cal_running = (cal_cnt != 32'h0);
  wire in_active = (state == ST_ACTIVE) || (state == ST_IDLE);
  wire wr_sleep = reg_wr && (reg_addr == `ADDR_SLEEP_CTRL);
  wire wr_clk = reg_wr && (reg_addr == `ADDR_CLOCK_SELECT);
  wire wr_power_control_register = reg_wr && (reg_addr == `ADDR_POWER_CONTROL);
  wire enter = wr_power_control_register && reg_wdata[`POWER_CONTROL_REGISTER_ENTER];
  wire cal_allowed = in_active && sys_clock_is_crystal && xtal_ok && !cal_dis && slow_sel; // RL22
  wire new_src_stable = src_sel ? rc_ok : xtal_ok;

  // calibration and clock source
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cal_cnt <= 32'h0;
      sys_clock_is_crystal <= 1'b0;
      slow_rc_cal_active <= 1'b0;
      fast_rc_cal_active <= 1'b0;
    end else begin
      // a started calibration always completes
      if (cal_running) // RL24
        cal_cnt <= cal_cnt - 32'h1;
      else if (cal_allowed)
        cal_cnt <= CAL_CYCLES[31:0];
      if (sys_clock_is_crystal != !src_sel && new_src_stable) // RL14
        sys_clock_is_crystal <= !src_sel; // RL13
      slow_rc_cal_active <= cal_running || cal_allowed;
      fast_rc_cal_active <= in_active && sys_clock_is_crystal && fast_rc_enable; // RL21
    end
  end

  // register state
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode <= `MODE_ACTIVE;
      cal_dis_req <= 1'b0;
      cal_dis <= 1'b0;
      pd_req <= 1'b1;
      pd <= 1'b1;
      rst_cause <= `RST_POWER_ON;
      src_sel <= 1'b1;
      slow_sel <= 1'b1;
      tick_speed <= `CLK_TICK_RESET;
      power_control_register_spare <= 6'h0;
    end else begin
      if (rst_sync[2])
        rst_cause <= `RST_WATCHDOG; // RL7
      else if (rst_sync[1])
        rst_cause <= `RST_PIN;
      else if (rst_sync[0])
        rst_cause <= `RST_POWER_ON;
      if (wr_sleep) begin
        mode <= reg_wdata[`SLP_MODE_HI:`SLP_MODE_LO]; // RL10
        cal_dis_req <= reg_wdata[`SLP_CAL_DIS]; // RL1
        pd_req <= reg_wdata[`SLP_PD];
      end else if (wake && state == ST_SLEEP) begin
        mode <= `MODE_ACTIVE; // RL12
        if (mode == `MODE_DEEP || mode == `MODE_DEEPEST) begin
          cal_dis_req <= 1'b0; // RL3
          slow_sel <= 1'b1; // RL17
          src_sel <= 1'b1;
        end
      end
      // disabling waits for fast RC as system clock; enabling is immediate
      if (!cal_dis_req || !sys_clock_is_crystal) // RL2
        cal_dis <= cal_dis_req;
      if (state == ST_SLEEP && wake && (mode == `MODE_DEEP || mode == `MODE_DEEPEST))
        cal_dis <= 1'b0; // RL3
      if (!pd_req || !cal_running) // RL9
        pd <= pd_req;
      if (wr_clk) begin
        src_sel <= reg_wdata[`CLK_SRC_SEL];
        // slow source only honoured while on fast RC
        if (!sys_clock_is_crystal) // RL20
          slow_sel <= reg_wdata[`CLK_SLOW_SEL];
        tick_speed <= reg_wdata[`CLK_TICK_HI:`CLK_TICK_LO];
      end
      if (wr_power_control_register)
        power_control_register_spare <= reg_wdata[`POWER_CONTROL_REGISTER_SPARE_HI:`POWER_CONTROL_REGISTER_SPARE_LO];
    end
  end

  // power mode sequencer
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_ACTIVE;
      power_state <= `MODE_ACTIVE;
      cpu_halt <= 1'b0;
    end else begin
      case (state)
        ST_ACTIVE: begin
          if (enter) begin // RL11
            if (mode == `MODE_ACTIVE)
              state <= ST_IDLE;
            else
              state <= ST_DRAIN;
            cpu_halt <= 1'b1;
          end
        end
        ST_DRAIN: begin
          // light and deep sleep wait out a running calibration
          if (!cal_running || mode == `MODE_DEEPEST) begin // RL23
            state <= ST_SLEEP;
            power_state <= mode;
          end
        end
        ST_SLEEP: begin
          if (wake) begin // RL12
            state <= ST_ACTIVE;
            power_state <= `MODE_ACTIVE;
            cpu_halt <= 1'b0;
          end
        end
        ST_IDLE: begin
          if (wake) begin
            state <= ST_ACTIVE;
            cpu_halt <= 1'b0;
          end
        end
        default: begin
          state <= ST_ACTIVE;
          power_state <= `MODE_ACTIVE;
          cpu_halt <= 1'b0;
        end
      endcase
    end
  end

  // oscillator enables and slow tick
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fast_crystal_enable <= 1'b0;
      fast_rc_enable <= 1'b1;
      slow_crystal_enable <= 1'b0;
      slow_rc_enable <= 1'b1; // RL17
      div_cnt <= 16'h0;
      slow_prev <= 1'b0;
      slow_tick <= 1'b0;
    end else begin
      if (state == ST_SLEEP) begin
        fast_crystal_enable <= 1'b0;
        fast_rc_enable <= 1'b0;
      end else begin
        // pd=1 powers down the source not selected
        fast_crystal_enable <= !pd || !src_sel || sys_clock_is_crystal; // RL8
        fast_rc_enable <= !pd || src_sel || !sys_clock_is_crystal;
      end
      slow_crystal_enable <= !slow_sel && !(state == ST_SLEEP && power_state == `MODE_DEEPEST); // RL19
      slow_rc_enable <= slow_sel && !(state == ST_SLEEP && power_state == `MODE_DEEPEST);
      slow_prev <= slow_lvl;
      // calibrated RC: slow clock derived from the fast clock
      if (slow_rc_cal_active) begin
        if (div_cnt >= SLOW_DIV[15:0] - 16'h1) begin
          div_cnt <= 16'h0;
          slow_tick <= 1'b1; // RL18
        end else begin
          div_cnt <= div_cnt + 16'h1;
          slow_tick <= 1'b0;
        end
      end else begin
        div_cnt <= 16'h0;
        slow_tick <= slow_lvl && !slow_prev; // RL18
      end
    end
  end

  // register reads, registered
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h0;
    end else if (reg_rd) begin
      if (reg_addr == `ADDR_SLEEP_CTRL)
        reg_rdata <= {cal_dis, xtal_ok && fast_crystal_enable, rc_ok && fast_rc_enable, // RL4 RL6
                      rst_cause, pd, mode};
      else if (reg_addr == `ADDR_CLOCK_SELECT)
        reg_rdata <= {slow_sel, src_sel, tick_speed, 2'h0, !sys_clock_is_crystal}; // RL15
      else if (reg_addr == `ADDR_POWER_CONTROL)
        reg_rdata <= {power_control_register_spare, 2'h0}; // RL11
      else
        reg_rdata <= 8'h0;
    end
  end
endmodule

// file: test/osc_model.sv
`timescale 1ns/1ps
module osc_model (
  // clock
  input wire clk,
  // enables from the block
  input wire fast_crystal_enable,
  input wire fast_rc_enable,
  input wire slow_crystal_enable,
  input wire slow_rc_enable,
  // oscillator status
  output reg crystal_ready = 0,
  output reg fast_rc_ready = 0,
  output reg slow_clock_in = 0
);
  integer xcnt = 0;
  integer rcnt = 0;
  integer scnt = 0;
  // crystal settles far slower than the rc source
  always @(negedge clk) begin
    xcnt <= fast_crystal_enable ? xcnt + 1 : 0;
    rcnt <= fast_rc_enable ? rcnt + 1 : 0;
    crystal_ready <= fast_crystal_enable && xcnt > 40;
    fast_rc_ready <= fast_rc_enable && rcnt > 4;
    scnt <= scnt + 1;
    // output stands still while no slow source runs
    if ((slow_crystal_enable || slow_rc_enable) && scnt % 8 == 0)
      slow_clock_in <= ~slow_clock_in;
  end
endmodule

// file: test/sleep_clock_ctrl_asserts.sv
`timescale 1ns/1ps
`include "sleep_clock_defs.vh"
module sleep_clock_ctrl_asserts #(
  parameter CAL_CYCLES = 20
) (
  // clock and reset
  input wire clk,
  input wire reset_n,
  // register port
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  // wake and oscillators
  input wire port_irq,
  input wire sleep_timer_irq,
  input wire crystal_ready,
  input wire slow_crystal_enable,
  input wire slow_rc_enable,
  input wire sys_clock_is_crystal,
  input wire fast_rc_cal_active,
  input wire slow_rc_cal_active,
  input wire [1:0] power_state,
  input wire cpu_halt
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  slow_excl_a: assert property (!(slow_crystal_enable && slow_rc_enable)) else $error("slow sources both on");
  rst_slow_a: assert property ($rose(reset_n) |-> slow_rc_enable) else $error("slow rc off after reset");
  cal_len_a: assert property ($rose(slow_rc_cal_active) |-> slow_rc_cal_active[*8]) else $error("cal cut short");
  sleep_cal_a: assert property (power_state == 2'h1 || power_state == 2'h2 |-> !slow_rc_cal_active)
    else $error("cal in sleep");
  halt_src_a: assert property ($rose(cpu_halt) |-> $past(reg_wr && reg_addr == `ADDR_POWER_CONTROL && reg_wdata[0]))
    else $error("halt without enter");
  wake_a: assert property (cpu_halt && (port_irq || sleep_timer_irq) |-> ##[1:8] !cpu_halt && power_state == 2'h0)
    else $error("no wake");
  switch_a: assert property ($rose(sys_clock_is_crystal) |-> $past(crystal_ready, 2)) else $error("early switch");
  fast_cal_a: assert property (fast_rc_cal_active |-> $past(sys_clock_is_crystal)) else $error("rc cal on rc");
  speed_a: assert property (reg_rd && reg_addr == `ADDR_CLOCK_SELECT |=> reg_rdata[0] == !$past(sys_clock_is_crystal))
    else $error("speed mismatch");
  cover property ($rose(slow_rc_cal_active));
  cover property ($rose(sys_clock_is_crystal));
  cover property (power_state == 2'h3);
endmodule

// file: test/sleep_clock_ctrl_test.sv
`timescale 1ns/1ps
`include "sleep_clock_defs.vh"
module sleep_clock_ctrl_test;
  reg clk = 0;
  reg reset_n = 0;
  reg [7:0] reg_addr = 0;
  reg reg_wr = 0;
  reg reg_rd = 0;
  reg [7:0] reg_wdata = 0;
  reg [2:0] ev = 0;
  reg [1:0] wake = 0;
  wire [7:0] reg_rdata;
  wire crystal_ready, fast_rc_ready, slow_clock_in, cpu_halt, slow_tick;
  wire fast_crystal_enable, fast_rc_enable, slow_crystal_enable, slow_rc_enable;
  wire sys_clock_is_crystal, fast_rc_cal_active, slow_rc_cal_active;
  wire [1:0] power_state;
  integer error_cnt = 0;
  integer num_checks = 0;
  integer m;
  always #2.5 clk = ~clk;
  sleep_clock_ctrl #(.CAL_CYCLES(20), .SLOW_DIV(8)) dut (.clk, .reset_n, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata, .por_event(ev[0]), .pin_reset_event(ev[1]), .watchdog_reset_event(ev[2]),
    .port_irq(wake[0]), .sleep_timer_irq(wake[1]), .crystal_ready, .fast_rc_ready, .slow_clock_in,
    .fast_crystal_enable, .fast_rc_enable, .slow_crystal_enable, .slow_rc_enable, .sys_clock_is_crystal,
    .fast_rc_cal_active, .slow_rc_cal_active, .power_state, .cpu_halt, .slow_tick);
  osc_model osc (.clk, .fast_crystal_enable, .fast_rc_enable, .slow_crystal_enable, .slow_rc_enable,
    .crystal_ready, .fast_rc_ready, .slow_clock_in);
  task results;
    begin
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  task chk(input [7:0] got, input [7:0] exp, input [7:0] mask);
    begin
      num_checks = num_checks + 1;
      if ((got & mask) !== (exp & mask)) begin
        error_cnt = error_cnt + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got & mask, exp & mask);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1;
      @(negedge clk);
      reg_wr = 0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] exp, input [7:0] mask);
    begin
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1;
      @(negedge clk);
      reg_rd = 0;
      chk(reg_rdata, exp, mask);
    end
  endtask
  initial begin
    #200000;
    error_cnt = error_cnt + 1;
    results;
  end
  initial begin
    repeat (10) @(negedge clk);
    reset_n = 1;
    repeat (20) @(negedge clk);
    rd(`ADDR_SLEEP_CTRL, 8'h24, 8'hff);
    rd(`ADDR_CLOCK_SELECT, 8'hc9, 8'hff);
    rd(`ADDR_POWER_CONTROL, 8'h00, 8'hff);
    rd(8'h00, 8'h00, 8'hff);
    // pin, watchdog, then power-on, so the last cause is power-on
    for (m = 1; m < 4; m = m + 1) begin
      ev = 3'(1 << (m % 3));
      repeat (4) @(negedge clk);
      ev = 3'h0;
      repeat (4) @(negedge clk);
      rd(`ADDR_SLEEP_CTRL, 8'((m % 3) << 3), 8'h18);
    end
    wr(`ADDR_SLEEP_CTRL, 8'h00);
    repeat (100) @(negedge clk);
    rd(`ADDR_SLEEP_CTRL, 8'h60, 8'hff);
    repeat (12800) @(negedge clk);
    wr(`ADDR_CLOCK_SELECT, 8'h89);
    repeat (10) @(negedge clk);
    rd(`ADDR_CLOCK_SELECT, 8'h88, 8'hff);
    repeat (50) if (slow_rc_cal_active !== 1'b1) @(negedge clk);
    wr(`ADDR_SLEEP_CTRL, 8'h04);
    rd(`ADDR_SLEEP_CTRL, 8'h00, 8'h04);
    // calibrated slow clock ticks once per SLOW_DIV fast cycles
    m = 0;
    repeat (80) begin
      @(negedge clk);
      if (slow_tick === 1'b1)
        m = m + 1;
    end
    chk(8'(m), 8'h0a, 8'hff);
    rd(`ADDR_SLEEP_CTRL, 8'h44, 8'hff);
    for (m = 1; m < 4; m = m + 1) begin
      wr(`ADDR_SLEEP_CTRL, 8'(8'h84 | m));
      wr(`ADDR_POWER_CONTROL, 8'h01);
      repeat (100) if (power_state !== 2'(m)) @(negedge clk);
      chk(8'(power_state), 8'(m), 8'h03);
      wake = m == 2 ? 2'h2 : 2'h1;
      repeat (20) if (cpu_halt !== 1'b0) @(negedge clk);
      wake = 2'h0;
      rd(`ADDR_SLEEP_CTRL, 8'h00, m > 1 ? 8'h83 : 8'h03);
    end
    results;
  end
endmodule
bind sleep_clock_ctrl sleep_clock_ctrl_asserts #(.CAL_CYCLES(CAL_CYCLES)) chk_i (.clk, .reset_n, .reg_addr,
  .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .port_irq, .sleep_timer_irq, .crystal_ready,
  .slow_crystal_enable, .slow_rc_enable, .sys_clock_is_crystal, .fast_rc_cal_active,
  .slow_rc_cal_active, .power_state, .cpu_halt);
